/* test/sifa_far_end.sv */
// Purpose: Far side: submodule flag lines
// Assumes: Flags come from logic on sys_clk
// Notes: One-cycle pulses, the shortest event a submodule makes
`timescale 1ns/1ps
`default_nettype none
module sifa_far_end
  import sifa_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Bench command and flag lines
  input wire logic [15:0] fire,
  output logic [15:0] flag_in
);
  // ****
  // Flag lines
  // ****
  // event raises line
  always_ff @(posedge sys_clk)
  begin
    flag_in <= fire;
  end
endmodule
`default_nettype wire

/* test/sifa_monitor.sv */
// Purpose: Port checker for sifa_top
// Assumes: One clock, synchronous reset
// Notes: Bound to every sifa_top instance
`timescale 1ns/1ps
`default_nettype none
module sifa_monitor
  import sifa_pkg::*;
#(
  parameter logic [15:0] IMPL_MASK = SIFA_IMPL_MASK_DEF
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Requests
  input wire logic [1:0] level_req,
  input wire logic irq,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_stat;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == SIFA_OFF_STATUS;
  endsequence
  a_wr_answer: assert property (s_wr_take |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed early");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write accepted while busy");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  a_rdata_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read bits set");
  a_unimpl_zero: assert property (s_rd_stat |=> (s_axi_rdata[15:0] & ~IMPL_MASK) == 16'h0)
    else $error("unable submodule flag read one");
  a_freeze_hold: assert property (!clk_en |=> $stable(level_req))
    else $error("request moved while frozen");
  a_reset_quiet: assert property ($rose(rst_n) |-> level_req == 2'h0 && !irq)
    else $error("request after reset");
endmodule
bind sifa_top sifa_monitor #(.IMPL_MASK(IMPL_MASK)) i_mon (.*);
`default_nettype wire

/* test/testbench.sv */
// Purpose: Self-checking bench for sifa_top
// Assumes: 20 MHz sys_clk; submodule 15 cannot interrupt
// Notes: Clears rely on arming by an earlier status read
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sifa_pkg::*;
  // ****
  // Bench
  // ****
  logic sys_clk, rst_n, clk_en, irq;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, level_req, rsp;
  logic [15:0] fire, flag_in;
  int fails, comparisons;
  sifa_top #(.IMPL_MASK(16'h7fff)) i_dut (.*);
  sifa_far_end i_far (.*);
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Data taken at the edge where rvalid is first seen high
  task automatic rdw(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic pulse(input logic [15:0] f);
    @(posedge sys_clk);
    fire <= f;
    @(posedge sys_clk);
    fire <= 16'h0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic t_reset();
    rdw(SIFA_OFF_STATUS);
    chk(rd, 32'h0);
    rdw(8'h40);
    chk(rd, 32'h0);
    chk(32'(rsp), 32'(SIFA_RESP_SLVERR));
    wr(8'h40, 32'h0);
    chk(32'(rsp), 32'(SIFA_RESP_SLVERR));
    $display("t_reset done");
  endtask
  task automatic t_poll();
    pulse(16'h8020);
    clk_en <= 1'b0;
    repeat (2) @(posedge sys_clk);
    clk_en <= 1'b1;
    rdw(SIFA_OFF_STATUS);
    chk(rd, 32'h20);
    chk(32'(level_req), 32'h0);
    rdw(SIFA_OFF_PEND0);
    chk(rd, 32'h0);
    $display("t_poll done");
  endtask
  task automatic t_enable();
    wr(SIFA_OFF_ENABLE1, 32'h20);
    wr(SIFA_OFF_ENABLE0, 32'h20);
    repeat (2) @(posedge sys_clk);
    chk(32'(level_req), 32'h3);
    rdw(SIFA_OFF_PEND1);
    chk(rd, 32'h20);
    wr(SIFA_OFF_ENABLE1, 32'h0);
    wr(SIFA_OFF_PEND0, 32'h0);
    chk(32'(rsp), 32'(SIFA_RESP_OKAY));
    repeat (2) @(posedge sys_clk);
    chk(32'(level_req), 32'h1);
    rdw(SIFA_OFF_PEND0);
    chk(rd, 32'h20);
    rdw(SIFA_OFF_EVT_STAT);
    chk(rd, 32'h3);
    chk(32'(irq), 32'h0);
    wr(SIFA_OFF_EVT_MASK, 32'h3);
    @(posedge sys_clk);
    chk(32'(irq), 32'h1);
    wr(SIFA_OFF_EVT_STAT, 32'h3);
    @(posedge sys_clk);
    chk(32'(irq), 32'h0);
    $display("t_enable done");
  endtask
  task automatic t_clear();
    pulse(16'h0008);
    wr(SIFA_OFF_STATUS, 32'hfff7);
    rdw(SIFA_OFF_STATUS);
    chk(rd, 32'h28);
    wr(SIFA_OFF_STATUS, 32'hffff);
    rdw(SIFA_OFF_STATUS);
    chk(rd, 32'h28);
    wr(SIFA_OFF_STATUS, 32'hffdf);
    repeat (2) @(posedge sys_clk);
    chk(32'(level_req), 32'h0);
    rdw(SIFA_OFF_STATUS);
    chk(rd, 32'h8);
    s_axi_wstrb <= 4'h2;
    wr(SIFA_OFF_STATUS, 32'h0);
    s_axi_wstrb <= 4'hf;
    rdw(SIFA_OFF_STATUS);
    chk(rd, 32'h8);
    wr(SIFA_OFF_STATUS, 32'hfff7);
    rdw(SIFA_OFF_STATUS);
    chk(rd, 32'h0);
    $display("t_clear done");
  endtask
  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fire} = '0;
    s_axi_wstrb = 4'hf;
    clk_en = 1'b1;
    fails = 0;
    comparisons = 0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_poll();
    t_enable();
    t_clear();
    summarize();
  end
  // A stuck handshake would otherwise hang the run
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    summarize();
  end
endmodule
`default_nettype wire

/* verilog/sifa_flag_if.sv */
// Purpose: Carries pending words and request bits between core and request stage
// Assumes: Single clock domain
// Notes: Pending words are combinational from the core
`timescale 1ns/1ps
`default_nettype none
interface sifa_flag_if;
  import sifa_pkg::*;
  logic [SIFA_GRP_W-1:0] pend0;
  logic [SIFA_GRP_W-1:0] pend1;
  logic [SIFA_LVL_N-1:0] req;
  modport core (output pend0, output pend1, input req);
  modport stage (input pend0, input pend1, output req);
endinterface
`default_nettype wire

/* verilog/sifa_pkg.sv */
// Purpose: Constants for the submodule interrupt flag aggregator
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses of the register file
package sifa_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned SIFA_GRP_W = 16;
  localparam int unsigned SIFA_LVL_N = 2;
  localparam int unsigned SIFA_ADDR_W = 8;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] SIFA_OFF_STATUS = 8'h00;
  localparam logic [7:0] SIFA_OFF_ENABLE0 = 8'h04;
  localparam logic [7:0] SIFA_OFF_ENABLE1 = 8'h08;
  localparam logic [7:0] SIFA_OFF_PEND0 = 8'h0c;
  localparam logic [7:0] SIFA_OFF_PEND1 = 8'h10;
  localparam logic [7:0] SIFA_OFF_EVT_STAT = 8'h14;
  localparam logic [7:0] SIFA_OFF_EVT_MASK = 8'h18;
  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [15:0] SIFA_STATUS_RST = 16'h0000;
  localparam logic [15:0] SIFA_ENABLE_RST = 16'h0000;
  localparam logic [15:0] SIFA_IMPL_MASK_DEF = 16'hffff;
  localparam logic [1:0] SIFA_EVT_RST = 2'h0;
  localparam logic [1:0] SIFA_RESP_OKAY = 2'h0;
  localparam logic [1:0] SIFA_RESP_SLVERR = 2'h2;
  // Event status bits: level request rose
  localparam int unsigned SIFA_EVT_W = 2;
endpackage

/* verilog/sifa_req_stage.sv */
// Purpose: Interrupt control section: turns pending words into per-level requests
// Assumes: Pending words are stable in the clock domain
// Notes: Requests are registered for clean outputs
`timescale 1ns/1ps
`default_nettype none
module sifa_req_stage
  import sifa_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Flag words
  sifa_flag_if.stage fl
);
  logic [SIFA_LVL_N-1:0] req_r;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      req_r <= '0;
    else if (clk_en)
      req_r <= {|fl.pend1, |fl.pend0};
  end
  assign fl.req = req_r;
endmodule
`default_nettype wire

/* verilog/sifa_top.sv */
// Purpose: Submodule interrupt flag aggregator with AXI4-Lite registers
// Assumes: Flag lines come from logic on sys_clk; one group of sixteen submodules
// Notes: Two request levels, each with its own enable and pending register
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sifa_top
  import sifa_pkg::*;
#(
  parameter logic [15:0] IMPL_MASK = SIFA_IMPL_MASK_DEF
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Submodule flag lines, group 0
  input wire logic [15:0] flag_in,
  // Request levels to the CPU
  output logic [1:0] level_req,
  output logic irq,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ****************************************
  // Storage
  // ****************************************
  logic [15:0] status_r;
  logic [15:0] armed_r;
  logic [15:0] enable0_r;
  logic [15:0] enable1_r;
  logic [1:0] evt_stat_r;
  logic [1:0] evt_mask_r;
  logic [1:0] req_q_r;
  logic [7:0] aw_addr_r;
  logic aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_have_r;
  logic do_wr;
  logic do_rd;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  logic [15:0] clr_req;
  logic [15:0] wr_lo;
  logic [1:0] evt_wr;
  logic [15:0] lane_mask;
  logic wsel_status;
  logic wsel_en0;
  logic wsel_en1;
  logic wsel_evt_stat;
  logic wsel_evt_mask;
  logic rsel_status;
  sifa_flag_if fl ();

  // ****************************************
  // Write channel capture
  // ****************************************
  // Ready only while running, so no beat is taken during a freeze and then lost
  assign s_axi_awready = clk_en && !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = clk_en && !w_have_r && !s_axi_bvalid;
  assign do_wr = aw_have_r && w_have_r && !s_axi_bvalid;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      else if (do_wr)
        aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end
    else if (clk_en)
    begin
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      else if (do_wr)
        w_have_r <= 1'b0;
    end
  end

  always_comb
  begin
    wr_hit = 1'b1;
    unique case ({aw_addr_r[7:2], 2'b00})
      SIFA_OFF_STATUS, SIFA_OFF_ENABLE0, SIFA_OFF_ENABLE1,
      SIFA_OFF_PEND0, SIFA_OFF_PEND1, SIFA_OFF_EVT_STAT, SIFA_OFF_EVT_MASK:
        wr_hit = 1'b1;
      default:
        wr_hit = 1'b0;
    endcase
  end

  // ****************************************
  // Write response
  // ****************************************
  // Responses hold through a freeze: the master must pause with clk_en as well
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SIFA_RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? SIFA_RESP_OKAY : SIFA_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Byte lanes apply to the low half word
  generate
    for (genvar b = 0; b < 16; b++)
    begin : g_lane
      assign lane_mask[b] = w_strb_r[b/8];
      assign wr_lo[b] = lane_mask[b] ? w_data_r[b] : 1'b1;
    end
  endgenerate

  // ****************************************
  // Address decode
  // ****************************************
  // Only word bits take part, so byte offsets inside a word alias one register
  assign wsel_status = do_wr && aw_addr_r[7:2] == SIFA_OFF_STATUS[7:2];
  assign wsel_en0 = do_wr && aw_addr_r[7:2] == SIFA_OFF_ENABLE0[7:2];
  assign wsel_en1 = do_wr && aw_addr_r[7:2] == SIFA_OFF_ENABLE1[7:2];
  assign wsel_evt_stat = do_wr && aw_addr_r[7:2] == SIFA_OFF_EVT_STAT[7:2];
  assign wsel_evt_mask = do_wr && aw_addr_r[7:2] == SIFA_OFF_EVT_MASK[7:2];
  assign rsel_status = do_rd && s_axi_araddr[7:2] == SIFA_OFF_STATUS[7:2];

  // ****************************************
  // Status flags
  // ****************************************
  // Only zeros clear
  assign clr_req = wsel_status ? ~wr_lo : 16'h0000;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      status_r <= SIFA_STATUS_RST;
    else if (clk_en)
      // Clear needs prior read; set wins over clear
      status_r <= ((status_r & ~(clr_req & armed_r)) | flag_in) & IMPL_MASK;
  end

  // Arm a bit when a status read returns it as one; a clear consumes the arm
  // Read-before-clear tracking
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      armed_r <= 16'h0000;
    else if (clk_en)
    begin
      if (rsel_status)
        armed_r <= (armed_r & ~clr_req) | status_r;
      else
        armed_r <= armed_r & ~clr_req & status_r;
    end
  end

  // ****************************************
  // Enables
  // ****************************************
  // Per-level enable bits
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      enable0_r <= SIFA_ENABLE_RST;
      enable1_r <= SIFA_ENABLE_RST;
    end
    else if (clk_en && do_wr)
    begin
      if (wsel_en0)
        enable0_r <= (enable0_r & ~lane_mask) | (w_data_r[15:0] & lane_mask);
      if (wsel_en1)
        enable1_r <= (enable1_r & ~lane_mask) | (w_data_r[15:0] & lane_mask);
    end
  end

  // ****************************************
  // Pending requests
  // ****************************************
  // Pending is status AND enable
  assign fl.pend0 = status_r & enable0_r;
  assign fl.pend1 = status_r & enable1_r;

  // ****************************************
  // Request forwarding
  // ****************************************
  // Forward to the control section
  sifa_req_stage u_stage (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .fl(fl.stage)
  );
  assign level_req = fl.req;

  // ****************************************
  // Interrupt events
  // ****************************************
  assign evt_wr = (wsel_evt_stat && w_strb_r[0]) ? w_data_r[1:0] : 2'b00;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      req_q_r <= SIFA_EVT_RST;
      evt_stat_r <= SIFA_EVT_RST;
    end
    else if (clk_en)
    begin
      req_q_r <= fl.req;
      // Rising request sets sticky bit; set wins over write-one clear
      evt_stat_r <= (evt_stat_r & ~evt_wr) | (fl.req & ~req_q_r);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      evt_mask_r <= SIFA_EVT_RST;
    else if (clk_en && wsel_evt_mask && w_strb_r[0])
      evt_mask_r <= w_data_r[1:0];
  end

  assign irq = |(evt_stat_r & evt_mask_r);

  // ****************************************
  // Read channel
  // ****************************************
  assign s_axi_arready = clk_en && !s_axi_rvalid;
  assign do_rd = s_axi_arvalid && s_axi_arready;

  // All sixteen flags in one read
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'b00})
      SIFA_OFF_STATUS: rd_word[15:0] = status_r;
      SIFA_OFF_ENABLE0: rd_word[15:0] = enable0_r;
      SIFA_OFF_ENABLE1: rd_word[15:0] = enable1_r;
      SIFA_OFF_PEND0: rd_word[15:0] = fl.pend0;
      SIFA_OFF_PEND1: rd_word[15:0] = fl.pend1;
      SIFA_OFF_EVT_STAT: rd_word[1:0] = evt_stat_r;
      SIFA_OFF_EVT_MASK: rd_word[1:0] = evt_mask_r;
      default: rd_hit = 1'b0;
    endcase
  end

  // ****************************************
  // Read response
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= SIFA_RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (do_rd)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? SIFA_RESP_OKAY : SIFA_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire
